/* File: include/sadc_pkg.sv */
// Shared constants, types and the register map of the converter sequencer.
// Contract
// - Successive approximation drives DAC from comparator feedback.
// - Fixed single converts once into channel register.
// - Fixed continuous rotates four registers, interrupt per four.
// - Scan single converts each selected channel once.
// - Scan continuous restarts from first selected channel.
// - Dual mode alternates, results in registers 0-3.
// - Dual mode interrupts once per four conversions.
// - Single step converts one channel, then waits.
// - Timer overflow starts; later overflows ignored while busy.
// - Immediate start mode begins conversion at once.
// - Pin edge starts; later edges ignored while busy.
// - Every start mode works with every mode.
// - Limit compare, inside inclusive or outside, interrupts.
// - Clearing limit enable turns limit function off.
// - Outside criterion checks four MSBs early.
// - Boundary status records channels that hit limits.
// - DAC mode drives result register 3 onto pin.
// - Divider ratio 1 to 8; software keeps range.
// - Runs in idle when enabled, interrupt wakes.
// - No operation in power-down modes.
package sadc_pkg;
  localparam logic [7:0]  ADR_CTRL   = 8'h00;
  localparam logic [7:0]  ADR_CHSEL  = 8'h04;
  localparam logic [7:0]  ADR_STAT   = 8'h08;
  localparam logic [7:0]  ADR_BHI    = 8'h0c;
  localparam logic [7:0]  ADR_BLO    = 8'h10;
  localparam logic [7:0]  ADR_BSTAT  = 8'h14;
  localparam logic [7:0]  ADR_RES0   = 8'h18;
  localparam logic [7:0]  ADR_RES1   = 8'h1c;
  localparam logic [7:0]  ADR_RES2   = 8'h20;
  localparam logic [7:0]  ADR_RES3   = 8'h24;
  localparam int          STAT_DONE  = 0;
  localparam int          STAT_BND   = 1;
  localparam int          STAT_BUSY  = 2;
  localparam logic [13:0] CTRL_RST   = 14'h0000;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [3:0]  MASK_RST   = 4'h1;
  localparam logic [7:0]  BHI_RST    = 8'hff;
  localparam logic [7:0]  SAR_TOP    = 8'h80;
  localparam logic [2:0]  MSB_BIT    = 3'h7;
  localparam logic [2:0]  EARLY_BIT  = 3'h4;
  localparam logic [1:0]  BIT_LAST   = 2'h3;
  localparam logic [1:0]  LAST_SLOT  = 2'h3;
  localparam int          CLK_KHZ    = 200000;
  localparam int          ADC_MIN_KHZ = 320;
  localparam int          ADC_MAX_KHZ = 8000;

  typedef enum logic [2:0] {
    M_FIX_ONE, M_FIX_RUN, M_SCAN_ONE, M_SCAN_RUN, M_DUAL_RUN, M_STEP
  } sadc_mode_e;

  typedef enum logic [1:0] {S_TIMER, S_IMM, S_EDGE} sadc_start_e;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SAMPLE, ST_CONV} sadc_state_e;

  typedef struct packed {
    logic        run_idle;
    logic [2:0]  div;
    logic        outside;
    logic        bnd_en;
    logic        done_ie;
    logic        dac_mode;
    logic        enable;
    sadc_start_e start;
    sadc_mode_e  mode;
  } sadc_ctrl_s;
endpackage

/* File: verilog/sadc_core.sv */
// Converter sequencer with approximation register and Wishbone slave.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/10ps
module sadc_core
  import sadc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        t0_ovf_i,
  input  wire logic        edge_start_input_i,
  input  wire logic        comp_i,
  input  wire logic        idle_i,
  input  wire logic        pdown_i,
  output logic      [1:0]  mux_sel_o,
  output logic             sample_o,
  output logic      [7:0]  dac_code_o,
  output logic             dac_pin_en_o,
  output logic             irq_o,
  output logic             wake_o,
  output logic             busy_o
);
  sadc_state_e     st, next_st;
  sadc_ctrl_s      ctrl, next_ctrl;
  logic [3:0]      chmask, next_chmask;
  logic [7:0]      bhi, next_bhi;
  logic [7:0]      blo, next_blo;
  logic [3:0]      bstat, next_bstat;
  logic [3:0][7:0] res, next_res;
  logic            done_f, next_done_f;
  logic            bnd_f, next_bnd_f;
  logic            imm_pend, next_imm_pend;
  logic [7:0]      approximation_register, next_sar;
  logic [2:0]      bitn, next_bitn;
  logic [1:0]      ph, next_ph;
  logic [2:0]      divc, next_divc;
  logic [1:0]      cur, next_cur;
  logic [1:0]      slot, next_slot;
  logic            early, next_early;
  logic [31:0]     next_dat;
  logic            next_ack;
  logic            e1, e2, e3, c1, c2;
  logic [2:0]      nx, fst, snd;
  logic            acc, wr, tick, freeze, trig, edge_seen, imm_go;
  logic [13:0]     cw;
  logic [7:0]      v;
  logic [1:0]      dest;
  logic            hit, done, end_seq, next_irq;

  function automatic logic [2:0] sadc_next(input logic [3:0] m, input logic [1:0] c,
                                           input logic wrap);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--)
      if (m[i] && (wrap || i > int'(c)))
        r = {1'b1, 2'(i)};
    return r;
  endfunction

  assign acc       = cyc_i & stb_i & ack_o;
  assign wr        = acc & we_i;
  assign freeze    = idle_i & ~ctrl.run_idle;
  assign tick      = (divc == ctrl.div) & ~freeze;
  assign edge_seen = e2 ^ e3;
  assign nx        = sadc_next(chmask, cur, 1'b0);
  assign fst       = sadc_next(chmask, 2'h0, 1'b1);
  assign snd       = sadc_next(chmask, fst[1:0], 1'b0);
  assign imm_go    = wr && adr_i == ADR_CTRL && cw[5] && cw[4:3] == S_IMM;

  always_comb
  begin
    cw = ctrl;
    if (sel_i[0])
      cw[7:0] = dat_i[7:0];
    if (sel_i[1])
      cw[13:8] = dat_i[13:8];
    case (ctrl.start)
      S_TIMER: trig = t0_ovf_i & ~freeze;
      S_IMM:   trig = imm_pend & ~freeze;
      S_EDGE:  trig = edge_seen & ~freeze;
      default: trig = 1'b0;
    endcase
  end

  always_comb
  begin
    next_ctrl     = ctrl;
    next_chmask   = chmask;
    next_bhi      = bhi;
    next_blo      = blo;
    next_bstat    = bstat;
    next_res      = res;
    next_done_f   = done_f;
    next_bnd_f    = bnd_f;
    next_imm_pend = imm_pend | imm_go;
    next_st       = st;
    next_sar      = approximation_register;
    next_bitn     = bitn;
    next_ph       = ph;
    next_cur      = cur;
    next_slot     = slot;
    next_early    = early;
    next_divc     = freeze ? divc : (tick ? 3'h0 : divc + 3'h1);
    v             = comp_s_val(c2, approximation_register, bitn);
    dest          = cur;
    hit           = 1'b0;
    done          = 1'b0;
    end_seq       = 1'b0;
    if (wr && sel_i[0])
      case (adr_i)
        ADR_CHSEL: next_chmask = dat_i[3:0];
        ADR_STAT:
        begin
          next_done_f = done_f & ~dat_i[STAT_DONE];
          next_bnd_f  = bnd_f & ~dat_i[STAT_BND];
        end
        ADR_BHI:   next_bhi = dat_i[7:0];
        ADR_BLO:   next_blo = dat_i[7:0];
        ADR_BSTAT: next_bstat = bstat & ~dat_i[3:0];
        ADR_RES3:  next_res[3] = dat_i[7:0];
        default:   next_done_f = next_done_f;
      endcase
    if (wr && adr_i == ADR_CTRL)
      next_ctrl = sadc_ctrl_s'(cw);
    case (st)
      ST_IDLE:
        if (ctrl.enable)
        begin
          next_st  = ST_ARMED;
          next_cur = fst[1:0];
        end
      ST_ARMED:
        if (trig)
        begin
          next_st       = ST_SAMPLE;
          next_imm_pend = imm_go;
          if (ctrl.mode != M_STEP || !chmask[cur])
          begin
            next_cur  = fst[1:0];
            next_slot = 2'h0;
          end
        end
      ST_SAMPLE:
        if (tick)
        begin
          next_st    = ST_CONV;
          next_sar   = SAR_TOP;
          next_bitn  = MSB_BIT;
          next_ph    = 2'h0;
          next_early = 1'b0;
        end
      ST_CONV:
        if (tick && ph != BIT_LAST)
          next_ph = ph + 2'h1;
        else if (tick)
        begin
          if (bitn == EARLY_BIT && ctrl.bnd_en && ctrl.outside &&
              (v[7:4] > bhi[7:4] || v[7:4] < blo[7:4]))
          begin
            hit        = 1'b1;
            next_early = 1'b1;
          end
          if (bitn != 3'h0)
          begin
            next_sar  = v | (8'h01 << (bitn - 3'h1));
            next_bitn = bitn - 3'h1;
            next_ph   = 2'h0;
          end
          else
          begin
            next_sar = v;
            if (ctrl.bnd_en && !early)
              hit = ctrl.outside ? (v > bhi || v < blo) : (v <= bhi && v >= blo);
            case (ctrl.mode)
              M_FIX_ONE:
              begin
                done    = 1'b1;
                end_seq = 1'b1;
              end
              M_FIX_RUN:
              begin
                dest      = slot;
                next_slot = slot + 2'h1;
                done      = slot == LAST_SLOT;
              end
              M_SCAN_ONE:
                if (nx[2])
                  next_cur = nx[1:0];
                else
                begin
                  done    = 1'b1;
                  end_seq = 1'b1;
                end
              M_SCAN_RUN:
                if (nx[2])
                  next_cur = nx[1:0];
                else
                begin
                  done     = 1'b1;
                  next_cur = fst[1:0];
                end
              M_DUAL_RUN:
              begin
                dest      = slot;
                next_slot = slot + 2'h1;
                done      = slot == LAST_SLOT;
                next_cur  = (slot[0] || !snd[2]) ? fst[1:0] : snd[1:0];
              end
              M_STEP:
              begin
                done     = 1'b1;
                end_seq  = 1'b1;
                next_cur = nx[2] ? nx[1:0] : fst[1:0];
              end
              default: end_seq = 1'b1;
            endcase
            next_res[dest] = v;
            next_st        = end_seq ? ST_ARMED : ST_SAMPLE;
          end
        end
      default: next_st = ST_IDLE;
    endcase
    // Set beats a clear in the same cycle, so no event is lost.
    if (done)
      next_done_f = 1'b1;
    if (hit)
    begin
      next_bnd_f      = 1'b1;
      next_bstat[cur] = 1'b1;
    end
    // Stopping abandons the conversion in flight rather than finishing it.
    if (!next_ctrl.enable || next_ctrl.dac_mode || pdown_i)
    begin
      next_st       = ST_IDLE;
      next_imm_pend = 1'b0;
    end
    next_irq = (next_done_f & next_ctrl.done_ie) | (next_bnd_f & next_ctrl.bnd_en);
    next_ack = cyc_i & stb_i & ~ack_o;
    case (adr_i)
      ADR_CTRL:  next_dat = {18'h0, ctrl};
      ADR_CHSEL: next_dat = {28'h0, chmask};
      ADR_STAT:  next_dat = {29'h0, busy_o, bnd_f, done_f};
      ADR_BHI:   next_dat = {24'h0, bhi};
      ADR_BLO:   next_dat = {24'h0, blo};
      ADR_BSTAT: next_dat = {28'h0, bstat};
      ADR_RES0:  next_dat = {24'h0, res[0]};
      ADR_RES1:  next_dat = {24'h0, res[1]};
      ADR_RES2:  next_dat = {24'h0, res[2]};
      ADR_RES3:  next_dat = {24'h0, res[3]};
      default:   next_dat = 32'h0;
    endcase
  end

  // The comparator is read two flops late, which is why each bit spans four ticks.
  function automatic logic [7:0] comp_s_val(input logic c, input logic [7:0] s,
                                            input logic [2:0] b);
    return c ? s : (s & ~(8'h01 << b));
  endfunction

  always_ff @(posedge clk_i)
  begin
    e1 <= edge_start_input_i;
    e2 <= e1;
    e3 <= e2;
    c1 <= comp_i;
    c2 <= c1;
    if (rst_i)
    begin
      st           <= ST_IDLE;
      ctrl         <= sadc_ctrl_s'(CTRL_RST);
      chmask       <= MASK_RST;
      bhi          <= BHI_RST;
      blo          <= BYTE_RST;
      bstat        <= 4'h0;
      res          <= '0;
      done_f       <= 1'b0;
      bnd_f        <= 1'b0;
      imm_pend     <= 1'b0;
      approximation_register          <= BYTE_RST;
      bitn         <= MSB_BIT;
      ph           <= 2'h0;
      divc         <= 3'h0;
      cur          <= 2'h0;
      slot         <= 2'h0;
      early        <= 1'b0;
      dat_o        <= 32'h0;
      ack_o        <= 1'b0;
      mux_sel_o    <= 2'h0;
      sample_o     <= 1'b0;
      dac_code_o   <= BYTE_RST;
      dac_pin_en_o <= 1'b0;
      irq_o        <= 1'b0;
      wake_o       <= 1'b0;
      busy_o       <= 1'b0;
    end
    else
    begin
      st           <= next_st;
      ctrl         <= next_ctrl;
      chmask       <= next_chmask;
      bhi          <= next_bhi;
      blo          <= next_blo;
      bstat        <= next_bstat;
      res          <= next_res;
      done_f       <= next_done_f;
      bnd_f        <= next_bnd_f;
      imm_pend     <= next_imm_pend;
      approximation_register          <= next_sar;
      bitn         <= next_bitn;
      ph           <= next_ph;
      divc         <= next_divc;
      cur          <= next_cur;
      slot         <= next_slot;
      early        <= next_early;
      dat_o        <= next_dat;
      ack_o        <= next_ack;
      mux_sel_o    <= next_cur;
      sample_o     <= next_st == ST_SAMPLE;
      dac_code_o   <= next_ctrl.dac_mode ? next_res[3] : next_sar;
      dac_pin_en_o <= next_ctrl.dac_mode;
      irq_o        <= next_irq;
      wake_o       <= idle_i & next_irq;
      busy_o       <= next_st == ST_SAMPLE || next_st == ST_CONV;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_sar_trial;
    (st == ST_CONV) |-> ((approximation_register & ~(8'hff << bitn)) == 8'h00);
  endproperty
  a_sar_trial: assert property (p_sar_trial) else $error("low bits set early");

  property p_start_cause;
    (st == ST_ARMED ##1 st == ST_SAMPLE) |-> $past(trig);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without trigger");

  property p_done_irq;
    (done_f && ctrl.done_ie) |-> irq_o;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done without irq");

  property p_dac;
    ctrl.dac_mode |-> (dac_code_o == res[3] && dac_pin_en_o);
  endproperty
  a_dac: assert property (p_dac) else $error("dac value wrong");

  property p_pdown;
    pdown_i |=> (st == ST_IDLE && !busy_o);
  endproperty
  a_pdown: assert property (p_pdown) else $error("runs in power-down");

  property p_stop;
    $fell(ctrl.enable) |-> (st == ST_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("not idle after stop");

  property p_bnd_off;
    !ctrl.bnd_en |=> !$rose(bnd_f);
  endproperty
  a_bnd_off: assert property (p_bnd_off) else $error("limit hit while off");

  property p_div;
    (tick && ctrl.div != 3'h0) ##1 $stable(ctrl.div) |-> !tick;
  endproperty
  a_div: assert property (p_div) else $error("divider too fast");

  property p_early;
    $rose(early) |-> (ctrl.outside && bnd_f);
  endproperty
  a_early: assert property (p_early) else $error("early hit wrong");

  c_dual: cover property ($rose(done_f) && ctrl.mode == M_DUAL_RUN);
  c_early: cover property ($rose(early));
  c_step: cover property ($rose(done_f) && ctrl.mode == M_STEP);
  c_bstat: cover property (bstat != 4'h0);
endmodule // sadc_core

/* File: verif/sadc_afe_model.sv */
// Behavioural analog front end: input mux, sample-hold, comparator and DAC pin.
`timescale 1ns/10ps
module sadc_afe_model
(
  input  wire logic        clk_i,
  input  wire logic [31:0] levels_i,
  input  wire logic [1:0]  mux_sel_i,
  input  wire logic        sample_i,
  input  wire logic [7:0]  dac_code_i,
  input  wire logic        dac_pin_en_i,
  output logic             comp_o,
  output logic      [7:0]  pin3_o
);
  logic [7:0] held = 8'h00;

  // The hold node follows the selected input only while sampling.
  // Comparator lags one cycle, inside the three cycles the sequencer allows.
  always @(posedge clk_i)
  begin
    if (sample_i)
      held <= levels_i[{mux_sel_i, 3'b000} +: 8];
    comp_o <= (held >= dac_code_i);
  end

  // A pin left to the converter shows its own input; DAC mode overrides it.
  assign pin3_o = dac_pin_en_i ? dac_code_i : levels_i[31:24];
endmodule // sadc_afe_model

/* File: verif/tb_sadc_core.sv */
// Self-checking bench for the converter sequencer with a front end model.
`timescale 1ns/10ps
module tb_sadc_core
  import sadc_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic        t0_ovf_i = 1'b0;
  logic        edge_start_input_i = 1'b0;
  logic        idle_i = 1'b0;
  logic        pdown_i = 1'b0;
  logic [31:0] levels = 32'h5aa52040;
  logic [31:0] dat_o, rdat;
  logic [7:0]  dac_code_o, pin3;
  logic [1:0]  mux_sel_o;
  logic        ack_o, comp, sample_o, dac_pin_en_o, irq_o, wake_o, busy_o;
  logic        smp_q = 1'b0;
  logic        irq_q = 1'b0;
  int          samples, irq_at, failures, compares;

  sadc_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .t0_ovf_i(t0_ovf_i), .edge_start_input_i(edge_start_input_i), .comp_i(comp),
    .idle_i(idle_i), .pdown_i(pdown_i), .mux_sel_o(mux_sel_o), .sample_o(sample_o),
    .dac_code_o(dac_code_o), .dac_pin_en_o(dac_pin_en_o), .irq_o(irq_o), .wake_o(wake_o),
    .busy_o(busy_o));

  sadc_afe_model afe (.clk_i(clk_i), .levels_i(levels), .mux_sel_i(mux_sel_o),
    .sample_i(sample_o), .dac_code_i(dac_code_o), .dac_pin_en_i(dac_pin_en_o),
    .comp_o(comp), .pin3_o(pin3));

  always #2.5 clk_i = ~clk_i;

  // Counts conversions by sample phases, and notes the count at the first interrupt.
  // The interrupt is noted first, as a continuous run starts its next sample on that edge.
  always @(negedge clk_i)
  begin
    if (irq_o === 1'b1 && !irq_q && irq_at == 0)
      irq_at = samples;
    if (sample_o === 1'b1 && !smp_q)
      samples++;
    smp_q = sample_o;
    irq_q = irq_o;
  end

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang();
    failures++;
    $display("[ERR] wait expected done seen timeout");
    end_sim();
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ack is read right after each rising edge, before that edge's updates land.
  // The request stands until the edge that samples ack high, and read data is taken there.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
    begin
      n++;
      if (n > 20)
        hang();
      @(posedge clk_i);
    end
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    wb(1'b0, a, 32'h0);
    check(what, rdat, e);
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic pulse();
    t0_ovf_i <= 1'b1;
    @(posedge clk_i);
    t0_ovf_i <= 1'b0;
  endtask

  // Clears a stale done flag first; a conversion is far longer than this write.
  task automatic wait_done();
    int n;
    n = 0;
    wr(ADR_STAT, 32'h1);
    rdat = 32'h0;
    while (rdat[STAT_DONE] !== 1'b1)
    begin
      n++;
      if (n > 1000)
        hang();
      wb(1'b0, ADR_STAT, 32'h0);
    end
  endtask

  // The slowest clock 200 MHz allows is still above range, so the slowest ratio is used.
  function automatic logic [31:0] ctl(input sadc_mode_e m, input sadc_start_e s,
                                      input logic [4:0] f);
    sadc_ctrl_s c;
    c = '0;
    c.mode = m;
    c.start = s;
    c.enable = 1'b1;
    c.div = 3'h7;
    {c.run_idle, c.outside, c.bnd_en, c.done_ie, c.dac_mode} = f;
    return {18'h00000, c};
  endfunction

  task automatic run(input logic [31:0] mask, input logic [31:0] c);
    wr(ADR_CHSEL, mask);
    wr(ADR_CTRL, c);
    wait_done();
  endtask

  initial
  begin
    gap(2);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADR_CHSEL, 32'h1, "chsel");
    rd(ADR_BHI, 32'hff, "bhi");
    wr(8'h40, 32'h5);
    rd(8'h40, 32'h0, "unmapped");
    $display("test reset done");
    idle_i <= 1'b1;
    samples = 0;
    run(32'h4, ctl(M_FIX_ONE, S_IMM, 5'b10010));
    check("irq", irq_o, 32'h1);
    check("wake", wake_o, 32'h1);
    rd(ADR_RES2, 32'ha5, "res2");
    check("fix n", samples, 32'h1);
    idle_i <= 1'b0;
    wr(ADR_STAT, 32'h1);
    gap(2);
    check("irq clr", irq_o, 32'h0);
    $display("test fixed single done");
    wr(ADR_CHSEL, 32'hb);
    wr(ADR_CTRL, ctl(M_SCAN_ONE, S_TIMER, 5'b0));
    samples = 0;
    gap(20);
    check("idle", busy_o, 32'h0);
    pulse();
    gap(20);
    pulse();
    wait_done();
    gap(40);
    check("scan n", samples, 32'h3);
    rd(ADR_RES0, 32'h40, "res0");
    rd(ADR_RES1, 32'h20, "res1");
    rd(ADR_RES3, 32'h5a, "res3");
    $display("test scan done");
    levels[15:8] <= 8'h33;
    wr(ADR_CHSEL, 32'h6);
    wr(ADR_CTRL, ctl(M_STEP, S_EDGE, 5'b0));
    samples = 0;
    edge_start_input_i <= 1'b1;
    gap(20);
    edge_start_input_i <= 1'b0;
    wait_done();
    gap(300);
    check("step one", samples, 32'h1);
    rd(ADR_RES1, 32'h33, "res1 step");
    edge_start_input_i <= 1'b1;
    wait_done();
    check("step two", samples, 32'h2);
    rd(ADR_RES2, 32'ha5, "res2 step");
    $display("test step done");
    wr(ADR_CHSEL, 32'h9);
    wr(ADR_CTRL, ctl(M_DUAL_RUN, S_TIMER, 5'b00010));
    samples = 0;
    irq_at = 0;
    pulse();
    wait_done();
    check("dual irq", irq_at, 32'h4);
    rd(ADR_RES1, 32'h5a, "dual res1");
    rd(ADR_RES2, 32'h40, "dual res2");
    wr(ADR_CTRL, 32'h0);
    gap(4);
    check("stop busy", busy_o, 32'h0);
    samples = 0;
    gap(300);
    check("stop n", samples, 32'h0);
    $display("test dual done");
    wr(ADR_BHI, 32'h50);
    wr(ADR_BLO, 32'h40);
    run(32'h1, ctl(M_FIX_ONE, S_IMM, 5'b00100));
    rd(ADR_STAT, 32'h3, "in stat");
    rd(ADR_BSTAT, 32'h1, "in bstat");
    wr(ADR_BSTAT, 32'hf);
    run(32'h2, ctl(M_FIX_ONE, S_IMM, 5'b01100));
    rd(ADR_BSTAT, 32'h2, "out bstat");
    wr(ADR_BSTAT, 32'hf);
    wr(ADR_STAT, 32'h2);
    run(32'h2, ctl(M_FIX_ONE, S_IMM, 5'b01000));
    rd(ADR_BSTAT, 32'h0, "bnd off");
    rd(ADR_STAT, 32'h1, "off stat");
    $display("test limits done");
    wr(ADR_CTRL, ctl(M_FIX_ONE, S_TIMER, 5'b00001));
    wr(ADR_RES3, 32'h3c);
    gap(4);
    check("dac en", dac_pin_en_o, 32'h1);
    check("dac pin", pin3, 32'h3c);
    wr(ADR_CTRL, 32'h0);
    pdown_i <= 1'b1;
    samples = 0;
    wr(ADR_CTRL, ctl(M_FIX_RUN, S_IMM, 5'b00010));
    gap(100);
    check("pdown", samples, 32'h0);
    pdown_i <= 1'b0;
    wr(ADR_CTRL, 32'h0);
    irq_at = 0;
    samples = 0;
    run(32'h2, ctl(M_FIX_RUN, S_IMM, 5'b00010));
    check("fix run irq", irq_at, 32'h4);
    rd(ADR_RES0, 32'h33, "fix run res0");
    $display("test dac power continuous done");
    wr(ADR_CTRL, 32'h0);
    wr(ADR_STAT, 32'h3);
    irq_at = 0;
    samples = 0;
    run(32'h5, ctl(M_SCAN_RUN, S_IMM, 5'b00010));
    check("scan run irq", irq_at, 32'h2);
    levels[23:16] <= 8'h77;
    wait_done();
    rd(ADR_RES2, 32'h77, "scan run res2");
    wr(ADR_CTRL, 32'h0);
    idle_i <= 1'b1;
    samples = 0;
    wr(ADR_CTRL, ctl(M_FIX_ONE, S_IMM, 5'b00000));
    gap(100);
    check("freeze n", samples, 32'h0);
    idle_i <= 1'b0;
    wait_done();
    check("thaw n", samples, 32'h1);
    $display("test scan run and idle done");
    end_sim();
  end
endmodule // tb_sadc_core
